//--- verilog/rxs_pkg.sv
// Constants shared by the receive status and receiver control block
package rxs_pkg;
  // Register byte offsets
  localparam logic [3:0] MAC_CTRL_OFS = 4'h0;
  localparam logic [3:0] CSUM_CTRL_OFS = 4'h4;
  localparam logic [3:0] RX_STAT_OFS = 4'h8;
  localparam logic [3:0] LAST_WORD_OFS = 4'hC;
  // Control and status field positions
  localparam int RX_ENABLE_BIT = 2;
  localparam int PASS_BAD_BIT = 16;
  localparam int CSUM_EN_BIT = 0;
  localparam int ERR_FLAG_BIT = 0;
  localparam int RUNNING_BIT = 1;
  // Status word field positions
  localparam int SW_FILTER_FAIL = 30;
  localparam int SW_LEN_LSB = 16;
  localparam int SW_ERR_SUM = 15;
  localparam int SW_BCAST = 13;
  localparam int SW_LEN_ERR = 12;
  localparam int SW_RUNT = 11;
  localparam int SW_MCAST = 10;
  localparam int SW_TOO_LONG = 7;
  localparam int SW_LATE_COL = 6;
  localparam int SW_ETH_TYPE = 5;
  localparam int SW_WDOG = 4;
  localparam int SW_MII_ERR = 3;
  localparam int SW_DRIBBLE = 2;
  localparam int SW_CRC_ERR = 1;
  // Frame size limits, in bytes
  localparam logic [13:0] RUNT_LIMIT = 14'h0040;
  localparam logic [13:0] MAX_FRAME = 14'h05EE;
  localparam logic [13:0] MAX_LEN_FIELD = 14'h05DC;
  localparam logic [13:0] MIN_LEN_FIELD = 14'h002E;
  localparam logic [13:0] HDR_BYTES = 14'h000E;
  localparam logic [13:0] LEN_OVERHEAD = 14'h0012;
  localparam logic [13:0] WDOG_LIMIT = 14'h0800;
  localparam logic [13:0] LEN_SAT = 14'h3FFF;
  // Dribble thresholds for MII and 10 Mbps modes
  localparam logic [2:0] DRIB_MII = 3'h4;
  localparam logic [2:0] DRIB_TEN = 3'h3;
  // Byte positions inside a frame
  localparam logic [13:0] DA_LAST = 14'h0005;
  localparam logic [13:0] TYPE_HI = 14'h000C;
  localparam logic [13:0] TYPE_LO = 14'h000D;
  // Checksum bytes appended after the payload
  localparam logic [1:0] CSUM_LAST = 2'h3;
  // Reset values
  localparam logic [31:0] MAC_CTRL_RST = 32'h0000_0000;
  localparam logic CSUM_EN_RST = 1'b0;
  // Receive sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RECV = 4'b0010,
    ST_CSUM = 4'b0100,
    ST_DONE = 4'b1000
  } rxs_state_type;
endpackage

//--- verilog/rxs_top.sv
// Receive status word builder, checksum append and receiver control
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (RULE1) Status bits 31, 14, 9:8 and 0 always read zero.
// (RULE2) Bit 30 set when the frame failed the address filter.
// (RULE3) Bits 29:16 carry the frame size in bytes.
// (RULE4) Bit 15 is the OR of bits 11, 7, 6 and 1.
// (RULE5) Bit 13 set for a broadcast destination address.
// (RULE6) Bit 12 set when length field disagrees with actual length.
// (RULE7) Bit 11 marks a runt, a frame shorter than 64 bytes.
// (RULE8) Runts reach the host only with pass-bad-frames set.
// (RULE9) Bit 10 set for a multicast destination address.
// (RULE10) Bit 7 flags frames over 1518 bytes, never truncated.
// (RULE11) Bit 6 flags a late collision.
// (RULE12) Bit 5 set when type field exceeds 1500, never under 14 bytes.
// (RULE13) Bit 4 flags watchdog expiry on very long frames.
// (RULE14) Bit 3 set when receive error was seen during the frame.
// (RULE15) Bit 2 flags dribble bits: 4 in MII, 3 or more at 10 Mbps.
// (RULE16) Dribble flag held clear when late collision is set.
// (RULE17) Bit 1 set on CRC mismatch or receive error.
// (RULE18) With offload enabled, 4 checksum bytes follow the payload.
// (RULE19) Host reads status word before the frame data.
// (RULE20) Clearing receive enable halts; halt gives one event pulse.
// (RULE21) Host may flush FIFOs, then sets receive enable again.
// (RULE22) FIFO underruns or status overrun raise the error flag.
// (RULE23) Status word is written after all frame data.
// (RULE24) Host soft-resets after any underrun.
// (RULE25) Error flag stays set until software clears it.
module rxs_top
  import rxs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // MAC receive byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_er,
  // MAC end-of-frame indications, valid with rx_last
  input wire logic mac_filter_fail,
  input wire logic mac_late_col,
  input wire logic mac_crc_bad,
  input wire logic [2:0] mac_dribble_bits,
  input wire logic mac_ten_mode,
  input wire logic [31:0] rx_csum,
  // FIFO error events
  input wire logic dfifo_underrun,
  input wire logic sfifo_underrun,
  input wire logic sfifo_overrun,
  // Data and status FIFO writes
  output logic dfifo_wr,
  output logic [7:0] dfifo_data,
  output logic dfifo_discard,
  output logic sfifo_wr,
  output logic [31:0] sfifo_data,
  // Receiver state
  output logic receiver_halted_event,
  output logic receive_error_flag
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  wire logic rst_n;
  rxs_state_type state_reg;
  logic [31:0] mac_control_reg;
  logic csum_en_reg;
  logic running_reg;
  logic [13:0] len_reg;
  logic bcast_reg;
  logic mcast_reg;
  logic [15:0] type_reg;
  logic er_seen_reg;
  logic filt_reg;
  logic late_reg;
  logic crc_reg;
  logic drib_reg;
  logic [31:0] csum_reg;
  logic [1:0] csum_idx_reg;
  logic [31:0] last_word_reg;
  logic [31:0] word;
  logic runt;
  logic take;
  logic err_evt;

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // The first byte of a frame is taken in idle, so none is lost
  assign take = rx_valid && ((state_reg == ST_RECV)
    || (state_reg == ST_IDLE && running_reg
        && mac_control_reg[RX_ENABLE_BIT]));
  assign runt = len_reg < RUNT_LIMIT;
  assign err_evt = dfifo_underrun | sfifo_underrun | sfifo_overrun;

  // Status word assembled from the per-frame flags
  always_comb begin
    word = 32'h0000_0000; // Reserved bits stay zero [RULE1]
    word[SW_FILTER_FAIL] = filt_reg; // [RULE2]
    word[SW_LEN_LSB +: 14] = len_reg; // [RULE3]
    word[SW_BCAST] = bcast_reg; // [RULE5]
    word[SW_LEN_ERR] = (type_reg <= 16'(MAX_LEN_FIELD))
      && (type_reg >= 16'(MIN_LEN_FIELD))
      && (len_reg != type_reg[13:0] + LEN_OVERHEAD); // [RULE6]
    word[SW_RUNT] = runt; // [RULE7]
    word[SW_MCAST] = mcast_reg && !bcast_reg; // [RULE9]
    word[SW_TOO_LONG] = len_reg > MAX_FRAME; // [RULE10]
    word[SW_LATE_COL] = late_reg; // [RULE11]
    word[SW_ETH_TYPE] = (type_reg > 16'(MAX_LEN_FIELD))
      && (len_reg >= HDR_BYTES); // [RULE12]
    word[SW_WDOG] = len_reg > WDOG_LIMIT; // [RULE13]
    word[SW_MII_ERR] = er_seen_reg; // [RULE14]
    word[SW_DRIBBLE] = drib_reg && !late_reg; // [RULE15] [RULE16]
    word[SW_CRC_ERR] = crc_reg || er_seen_reg; // [RULE17]
    word[SW_ERR_SUM] = word[SW_RUNT] | word[SW_TOO_LONG]
      | word[SW_LATE_COL] | word[SW_CRC_ERR]; // [RULE4]
  end

  // Register writes; receive enable steers the sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mac_control_reg <= MAC_CTRL_RST;
      csum_en_reg <= CSUM_EN_RST;
    end else if (reg_wr) begin
      if (reg_addr == MAC_CTRL_OFS)
        mac_control_reg <= reg_wdata; // [RULE20] [RULE21]
      if (reg_addr == CSUM_CTRL_OFS)
        csum_en_reg <= reg_wdata[CSUM_EN_BIT];
    end
  end

  // Sticky error flag; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      receive_error_flag <= 1'b0;
    else if (err_evt)
      receive_error_flag <= 1'b1; // [RULE22] [RULE25]
    else if (reg_wr && reg_addr == RX_STAT_OFS
             && reg_wdata[ERR_FLAG_BIT])
      receive_error_flag <= 1'b0;
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          MAC_CTRL_OFS: reg_rdata <= mac_control_reg;
          CSUM_CTRL_OFS: reg_rdata <= {31'h0, csum_en_reg};
          RX_STAT_OFS: reg_rdata <= {30'h0, running_reg,
                                     receive_error_flag};
          LAST_WORD_OFS: reg_rdata <= last_word_reg;
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sequencer: frames start only while running, halt between frames
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      running_reg <= 1'b0;
      receiver_halted_event <= 1'b0;
    end else begin
      receiver_halted_event <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (!mac_control_reg[RX_ENABLE_BIT]) begin
            running_reg <= 1'b0;
            receiver_halted_event <= running_reg; // [RULE20]
          end else begin
            running_reg <= 1'b1;
            // A byte in the first enabled cycle is skipped, later ones start a frame; the first
            // byte is taken here, so a one-byte frame ends at once
            if (running_reg && rx_valid && !rx_last)
              state_reg <= ST_RECV;
            else if (running_reg && rx_valid)
              state_reg <= csum_en_reg ? ST_CSUM : ST_DONE;
          end
        end
        ST_RECV: begin
          if (rx_valid && rx_last)
            state_reg <= csum_en_reg ? ST_CSUM : ST_DONE;
        end
        ST_CSUM: begin
          if (csum_idx_reg == CSUM_LAST)
            state_reg <= ST_DONE; // [RULE18]
        end
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Per-frame flags and byte count; the count saturates
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_reg <= 14'h0000;
      bcast_reg <= 1'b0;
      mcast_reg <= 1'b0;
      type_reg <= 16'h0000;
      er_seen_reg <= 1'b0;
      filt_reg <= 1'b0;
      late_reg <= 1'b0;
      crc_reg <= 1'b0;
      drib_reg <= 1'b0;
      csum_reg <= 32'h0000_0000;
    end else if (take) begin
      if (len_reg != LEN_SAT)
        len_reg <= len_reg + 14'h0001; // [RULE3]
      if (len_reg == 14'h0000)
        mcast_reg <= rx_data[0]; // [RULE9]
      if (len_reg <= DA_LAST && rx_data != 8'hFF)
        bcast_reg <= 1'b0; // [RULE5]
      if (len_reg == TYPE_HI)
        type_reg[15:8] <= rx_data;
      if (len_reg == TYPE_LO)
        type_reg[7:0] <= rx_data;
      if (rx_er)
        er_seen_reg <= 1'b1; // [RULE14]
      if (rx_last) begin
        filt_reg <= mac_filter_fail;
        late_reg <= mac_late_col;
        crc_reg <= mac_crc_bad;
        drib_reg <= mac_ten_mode ? (mac_dribble_bits >= DRIB_TEN)
                    : (mac_dribble_bits == DRIB_MII); // [RULE15]
        csum_reg <= rx_csum;
      end
    end else if (state_reg == ST_IDLE || state_reg == ST_DONE) begin
      // Cleared as the word is pushed, ready for the next first byte
      len_reg <= 14'h0000;
      bcast_reg <= 1'b1;
      mcast_reg <= 1'b0;
      type_reg <= 16'h0000;
      er_seen_reg <= 1'b0;
    end
  end

  // Data FIFO: frame bytes, then checksum bytes low byte first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dfifo_wr <= 1'b0;
      dfifo_data <= 8'h00;
      csum_idx_reg <= 2'h0;
    end else begin
      dfifo_wr <= 1'b0;
      if (take) begin
        dfifo_wr <= 1'b1; // Whole frame kept, never truncated [RULE10]
        dfifo_data <= rx_data;
        csum_idx_reg <= 2'h0;
      end else if (state_reg == ST_CSUM) begin
        dfifo_wr <= 1'b1; // [RULE18]
        dfifo_data <= csum_reg[{csum_idx_reg, 3'h0} +: 8];
        csum_idx_reg <= csum_idx_reg + 2'h1;
      end
    end
  end

  // Status push after the data, or discard of a dropped runt
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfifo_wr <= 1'b0;
      sfifo_data <= 32'h0000_0000;
      dfifo_discard <= 1'b0;
      last_word_reg <= 32'h0000_0000;
    end else begin
      sfifo_wr <= 1'b0;
      dfifo_discard <= 1'b0;
      if (state_reg == ST_DONE) begin
        if (runt && !mac_control_reg[PASS_BAD_BIT]) begin
          dfifo_discard <= 1'b1; // [RULE8]
        end else begin
          sfifo_wr <= 1'b1; // Follows last data write [RULE23]
          sfifo_data <= word;
          last_word_reg <= word;
        end
      end
    end
  end

  // Checks on the status word and the control sequence
  resv_bits_a: assert property ( // [RULE1]
    @(posedge sys_clk) disable iff (!rst_n)
    sfifo_wr |-> (sfifo_data[31] == 1'b0 && sfifo_data[14] == 1'b0
      && sfifo_data[9:8] == 2'h0 && sfifo_data[0] == 1'b0))
    else $error("reserved status bits not zero");

  err_summary_a: assert property ( // [RULE4]
    @(posedge sys_clk) disable iff (!rst_n)
    sfifo_wr |-> sfifo_data[15] == (sfifo_data[11] | sfifo_data[7]
      | sfifo_data[6] | sfifo_data[1]))
    else $error("error summary mismatch");

  stat_after_data_a: assert property ( // [RULE23]
    @(posedge sys_clk) disable iff (!rst_n)
    sfifo_wr |-> !dfifo_wr && $past(state_reg) == ST_DONE)
    else $error("status written beside data");

  runt_pass_a: assert property ( // [RULE8]
    @(posedge sys_clk) disable iff (!rst_n)
    (sfifo_wr && sfifo_data[11]) |-> $past(mac_control_reg[16]))
    else $error("runt forwarded without pass-bad");

  dribble_clear_a: assert property ( // [RULE16]
    @(posedge sys_clk) disable iff (!rst_n)
    (sfifo_wr && sfifo_data[6]) |-> !sfifo_data[2])
    else $error("dribble set with late collision");

  short_type_a: assert property ( // [RULE12]
    @(posedge sys_clk) disable iff (!rst_n)
    (sfifo_wr && sfifo_data[29:16] < 14'h000E) |-> !sfifo_data[5])
    else $error("frame type set on short runt");

  halt_pulse_a: assert property ( // [RULE20]
    @(posedge sys_clk) disable iff (!rst_n)
    receiver_halted_event |=> !receiver_halted_event && !running_reg)
    else $error("halt event not a single pulse");

  err_sticky_a: assert property ( // [RULE22]
    @(posedge sys_clk) disable iff (!rst_n)
    err_evt |=> receive_error_flag [*2])
    else $error("error flag not held");

  csum_bytes_a: assert property ( // [RULE18]
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(state_reg == ST_CSUM) |-> (state_reg == ST_CSUM) [*4]
      ##1 state_reg == ST_DONE)
    else $error("checksum append not four bytes");

  first_byte_a: assert property ( // [RULE3]
    @(posedge sys_clk) disable iff (!rst_n)
    (state_reg == ST_IDLE && running_reg && rx_valid
      && mac_control_reg[RX_ENABLE_BIT]) |=> dfifo_wr)
    else $error("first frame byte not taken");

  err_hold_a: assert property ( // [RULE25]
    @(posedge sys_clk) disable iff (!rst_n)
    (receive_error_flag && !(reg_wr && reg_addr == RX_STAT_OFS))
      |=> receive_error_flag)
    else $error("error flag dropped without clear");

  halt_stopped_a: assert property ( // [RULE20]
    @(posedge sys_clk) disable iff (!rst_n)
    receiver_halted_event |-> !$past(mac_control_reg[RX_ENABLE_BIT]))
    else $error("halt event while enabled");

  bcast_only_a: assert property ( // [RULE9]
    @(posedge sys_clk) disable iff (!rst_n)
    sfifo_wr |-> !(sfifo_data[13] && sfifo_data[10]))
    else $error("multicast set on broadcast");

  frame_done_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n) sfifo_wr);
  runt_drop_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n) dfifo_discard);
  halt_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n) receiver_halted_event);
  csum_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n) state_reg == ST_CSUM);
  err_c: cover property (
    @(posedge sys_clk) disable iff (!rst_n) receive_error_flag);

endmodule
`default_nettype wire

//--- verification/rxs_host_model.sv
// Host-side model that collects the block's data and status writes
`timescale 1ns/1ps
`default_nettype none
module rxs_host_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // FIFO writes from the block
  input wire logic dfifo_wr,
  input wire logic [7:0] dfifo_data,
  input wire logic dfifo_discard,
  input wire logic sfifo_wr,
  input wire logic [31:0] sfifo_data,
  // What the host has collected
  output logic [31:0] stat_word,
  output logic [15:0] stat_bytes,
  output logic [15:0] pend,
  output logic [31:0] tail,
  output logic [7:0] stat_cnt,
  output logic [7:0] drop_cnt
);
  // Soft reset puts the host reads back in step with the block
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stat_word <= 32'h0;
      stat_bytes <= 16'h0;
      pend <= 16'h0;
      tail <= 32'h0;
      stat_cnt <= 8'h0;
      drop_cnt <= 8'h0;
    end else begin
      if (dfifo_wr) begin
        pend <= pend + 16'h1;
        tail <= {dfifo_data, tail[31:8]}; // Last four bytes seen
      end
      // Status word sizes the data read of its frame
      if (sfifo_wr) begin
        stat_word <= sfifo_data;
        stat_bytes <= pend;
        stat_cnt <= stat_cnt + 8'h1;
        pend <= 16'h0;
      end
      // A dropped frame is flushed from the host view
      if (dfifo_discard) begin
        drop_cnt <= drop_cnt + 8'h1;
        pend <= 16'h0;
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the receive status and control block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import rxs_pkg::*;
;
  typedef struct packed {
    logic [13:0] len;
    logic [7:0] da;
    logic [15:0] typ;
    logic [7:0] fl; // filt, late, crc, er, ten, dribble[2:0]
    logic [31:0] exp;
  } rxs_row_type;
  logic sys_clk = 1'h0;
  logic rstn = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic rx_valid = 1'h0;
  logic [7:0] rx_data = 8'h0;
  logic rx_last = 1'h0;
  logic rx_er = 1'h0;
  logic mac_filter_fail = 1'h0;
  logic mac_late_col = 1'h0;
  logic mac_crc_bad = 1'h0;
  logic [2:0] mac_dribble_bits = 3'h0;
  logic mac_ten_mode = 1'h0;
  logic [31:0] rx_csum = 32'hA1B2C3D4;
  logic dfifo_underrun = 1'h0;
  logic sfifo_underrun = 1'h0;
  logic sfifo_overrun = 1'h0;
  logic dfifo_wr, dfifo_discard, sfifo_wr;
  logic [7:0] dfifo_data, stat_cnt, drop_cnt, c0;
  logic [31:0] sfifo_data, stat_word, tail;
  logic receiver_halted_event, receive_error_flag;
  logic [15:0] stat_bytes, pend;
  int failures = 0;
  int cmp_count = 0;
  int halt_cnt = 0;
  // Frame rows: length, address byte, type field, flags, status
  rxs_row_type rows [15] = '{
    '{14'h40, 8'h02, 16'h0800, 8'h00, 32'h0040_0020},
    '{14'h40, 8'hFF, 16'h002E, 8'h00, 32'h0040_2000},
    '{14'h41, 8'h01, 16'h002E, 8'h00, 32'h0041_1400},
    '{14'h14, 8'h02, 16'h0800, 8'h80, 32'h4014_8820},
    '{14'h0A, 8'h02, 16'h0800, 8'h00, 32'h000A_8800},
    '{14'h40, 8'h02, 16'h0800, 8'h44, 32'h0040_8060},
    '{14'h40, 8'h02, 16'h0800, 8'h04, 32'h0040_0024},
    '{14'h40, 8'h02, 16'h0800, 8'h03, 32'h0040_0020},
    '{14'h40, 8'h02, 16'h0800, 8'h0B, 32'h0040_0024},
    '{14'h40, 8'h02, 16'h0800, 8'h20, 32'h0040_8022},
    '{14'h40, 8'h02, 16'h0800, 8'h10, 32'h0040_802A},
    '{14'h5EF, 8'h02, 16'h0800, 8'h00, 32'h05EF_80A0},
    '{14'h5EE, 8'h02, 16'h05DC, 8'h00, 32'h05EE_0000},
    '{14'h801, 8'h02, 16'h0800, 8'h00, 32'h0801_80B0},
    '{14'h800, 8'h02, 16'h0800, 8'h00, 32'h0800_80A0}
  };
  rxs_top u_rxs_top (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rx_valid, .rx_data, .rx_last, .rx_er,
    .mac_filter_fail, .mac_late_col, .mac_crc_bad, .mac_dribble_bits,
    .mac_ten_mode, .rx_csum, .dfifo_underrun, .sfifo_underrun,
    .sfifo_overrun, .dfifo_wr, .dfifo_data, .dfifo_discard, .sfifo_wr,
    .sfifo_data, .receiver_halted_event, .receive_error_flag);
  rxs_host_model u_rxs_host_model (.sys_clk, .rstn, .dfifo_wr,
    .dfifo_data, .dfifo_discard, .sfifo_wr, .sfifo_data, .stat_word,
    .stat_bytes, .pend, .tail, .stat_cnt, .drop_cnt);
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  // Count halt pulses so a stretched pulse shows up
  always @(posedge sys_clk) if (receiver_halted_event === 1'h1) halt_cnt++;
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input string nm, input logic [3:0] a, logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 check(nm, e, reg_rdata);
  endtask
  // One frame, flags held through it, then a gap long enough for status
  task automatic send(input rxs_row_type r);
    for (int i = 0; i < int'(r.len); i++) begin
      @(posedge sys_clk);
      rx_valid <= 1'h1;
      rx_data <= (i < 6) ? r.da : (i == 12) ? r.typ[15:8] :
        (i == 13) ? r.typ[7:0] : 8'(i);
      rx_last <= (i == int'(r.len) - 1);
      rx_er <= r.fl[4] && (i == 1);
      {mac_filter_fail, mac_late_col, mac_crc_bad} <= r.fl[7:5];
      mac_ten_mode <= r.fl[3];
      mac_dribble_bits <= r.fl[2:0];
    end
    @(posedge sys_clk);
    rx_valid <= 1'h0;
    rx_last <= 1'h0;
    rx_er <= 1'h0;
    repeat (12) @(posedge sys_clk);
  endtask
  // Watchdog well beyond the roughly 8300 cycles the tests need
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    results();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1 check("idle outputs", 32'h0,
      32'({dfifo_wr, dfifo_discard, sfifo_wr, receiver_halted_event,
      receive_error_flag}));
    rd("mac ctrl", MAC_CTRL_OFS, MAC_CTRL_RST);
    rd("csum ctrl", CSUM_CTRL_OFS, 32'(CSUM_EN_RST));
    rd("rx stat", RX_STAT_OFS, 32'h0);
    rd("unmapped", 4'h2, 32'h0);
    $display("reset test done");
    wr(MAC_CTRL_OFS, 32'h0001_0004);
    repeat (3) @(posedge sys_clk);
    rd("running", RX_STAT_OFS, 32'h2);
    foreach (rows[n]) begin
      c0 = stat_cnt;
      send(rows[n]);
      check("pushes", 32'(c0 + 8'h1), 32'(stat_cnt));
      check("status", rows[n].exp, stat_word);
      check("bytes", 32'(rows[n].len), 32'(stat_bytes));
    end
    rd("last word", LAST_WORD_OFS, rows[14].exp);
    $display("table test done");
    wr(CSUM_CTRL_OFS, 32'h1);
    send(rows[0]);
    check("csum bytes", 32'h44, 32'(stat_bytes));
    check("csum order", rx_csum, tail);
    check("csum status", rows[0].exp, stat_word);
    wr(CSUM_CTRL_OFS, 32'h0);
    wr(MAC_CTRL_OFS, 32'h4);
    c0 = drop_cnt;
    send(rows[3]);
    check("drops", 32'(c0 + 8'h1), 32'(drop_cnt));
    check("no push", rows[0].exp, stat_word);
    $display("checksum and runt test done");
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      {dfifo_underrun, sfifo_underrun, sfifo_overrun} <= 3'(4 >> k);
      @(posedge sys_clk);
      {dfifo_underrun, sfifo_underrun, sfifo_overrun} <= 3'h0;
      repeat (5) @(posedge sys_clk);
      #1 check("err flag", 32'h1, 32'(receive_error_flag));
      rd("err stat", RX_STAT_OFS, 32'h3);
      wr(RX_STAT_OFS, 32'h1);
      repeat (2) @(posedge sys_clk);
      #1 check("flag clear", 32'h0, 32'(receive_error_flag));
    end
    $display("error flag test done");
    halt_cnt = 0;
    wr(MAC_CTRL_OFS, 32'h0);
    repeat (10) @(posedge sys_clk);
    check("halt pulses", 32'h1, 32'(halt_cnt));
    rd("stopped", RX_STAT_OFS, 32'h0);
    send(rows[6]);
    check("ignored", 32'h0, 32'(pend));
    wr(MAC_CTRL_OFS, 32'h4);
    repeat (3) @(posedge sys_clk);
    rd("restarted", RX_STAT_OFS, 32'h2);
    send(rows[6]);
    check("after restart", rows[6].exp, stat_word);
    check("frame tail", 32'h3F3E_3D3C, tail);
    $display("halt test done");
    // Reset in mid-run with the flag set and the receiver enabled
    dfifo_underrun <= 1'h1;
    @(posedge sys_clk);
    dfifo_underrun <= 1'h0;
    rstn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1 check("reset flag", 32'h0, 32'(receive_error_flag));
    rd("reset ctrl", MAC_CTRL_OFS, MAC_CTRL_RST);
    rd("reset stat", RX_STAT_OFS, 32'h0);
    $display("mid-run reset test done");
    results();
  end
endmodule
`default_nettype wire
